// >>> rtl/fcx_params.svh
// fcx_params.svh: named constants of the compare, classify and exchange unit
// assumes: included by the package and the unit; holds definitions only
`ifndef FCX_PARAMS_SVH
`define FCX_PARAMS_SVH
// escape bytes and second-byte patterns of the handled operations
`define FCX_ESC_DA      8'hDA
`define FCX_ESC_D9      8'hD9
`define FCX_ESC_DD      8'hDD
`define FCX_MRM_UCOM    5'h1C
`define FCX_MRM_UCOMP   5'h1D
`define FCX_MRM_XCH     5'h19
`define FCX_MRM_UCOMPP  8'hE9
`define FCX_MRM_XAM     8'hE5
`define FCX_MRM_XTRACT  8'hF4
// extended-real format
`define FCX_EXP_MAX     15'h7FFF
`define FCX_BIAS        15'h3FFF
`define FCX_JBIT        63
`define FCX_QBIT        62
`define FCX_INF_SIG     64'h8000000000000000
// condition codes as {c3, c2, c0}
`define FCX_CC_GT       3'h0
`define FCX_CC_LT       3'h1
`define FCX_CC_EQ       3'h4
`define FCX_CC_UN       3'h7
`define FCX_CL_UNS      3'h0
`define FCX_CL_NAN      3'h1
`define FCX_CL_NRM      3'h2
`define FCX_CL_INF      3'h3
`define FCX_CL_ZER      3'h4
`define FCX_CL_EMP      3'h5
`define FCX_CL_DEN      3'h6
// register port map
`define FCX_AW          4
`define FCX_A_CTRL      4'h0
`define FCX_A_STAT      4'h1
`define FCX_A_TAG       4'h2
`define FCX_A_SEL       4'h3
`define FCX_A_D0        4'h4
`define FCX_A_D1        4'h5
`define FCX_A_D2        4'h6
`define FCX_A_COMMIT    4'h7
`define FCX_A_ISTAT     4'h8
`define FCX_A_IMASK     4'h9
`define FCX_WORD        32
`define FCX_D1_SH       32
`define FCX_D2_SH       64
// reset values: both exceptions masked, whole stack empty
`define FCX_CTL_RST     2'h3
`endif

// >>> rtl/fcx_pkg.sv
// fcx_pkg.sv: types shared by the unit and its bench
// assumes: fcx_params.svh on the include path
`include "fcx_params.svh"
package fcx_pkg;
  typedef enum logic [2:0] {OP_NONE, OP_UCOM, OP_UCOMP, OP_UCOMPP,
                            OP_XAM, OP_XCH, OP_XTRACT} fcx_op_t;
  typedef struct packed {
    logic        sign;  // sign bit
    logic [14:0] exp;   // biased exponent
    logic [63:0] sig;   // significand, explicit integer bit
  } fcx_ext_t;
  typedef struct packed {
    logic valid;        // one-cycle issue strobe
    logic [7:0] esc;    // first opcode byte
    logic [7:0] mrm;    // second opcode byte
  } fcx_instr_t;
  typedef struct packed {
    logic zero, den, inf, nan, snan, uns;
  } fcx_kind_t;
  typedef struct packed {
    logic c3, c2, c1, c0;  // condition bits
    logic sf, ze, de, ie;  // sticky exception flags
  } fcx_stat_t;
  typedef struct packed {
    logic zm;  // zero-divide mask
    logic im;  // invalid mask bit
  } fcx_ctl_t;
  typedef struct packed {
    logic nm, sf, ze, de, ie, done;
  } fcx_evt_t;
endpackage

// >>> rtl/fcx_unit.sv
// fcx_unit.sv: unordered compare, examine, exchange and split of a register stack
// assumes: instruction issue is synchronous to ref_clk, one strobe per cycle;
// registers reached over a plain address/strobe port, read data one cycle later
`timescale 1ns/1ns
`include "fcx_params.svh"
module fcx_unit
  import fcx_pkg::*;
#(
  parameter int STK_DEPTH = 8  // physical stack registers
)(
  input  wire fcx_pkg::fcx_instr_t instr_in,
  input  wire logic                emulate_bit,
  input  wire logic                task_switched_bit,
  input  wire logic [`FCX_AW-1:0]  reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [31:0]              reg_rdata,
  output logic                     instr_done,
  output logic                     device_unavailable_fault,
  output fcx_pkg::fcx_stat_t       status_word,
  output logic                     irq,
  input  wire logic                ref_clk,
  input  wire logic                nrst
);
  import fcx_pkg::*;
  localparam int PW = $clog2(STK_DEPTH);

  // the opcode index is three bits, so the stack must cover it
  if (STK_DEPTH < 8 || (1 << PW) != STK_DEPTH)
  begin
    $error("STK_DEPTH must be a power of two, at least 8");
  end

  // register class of one extended value
  function automatic fcx_kind_t classify(input fcx_ext_t v);
    fcx_kind_t k;
    k = '0;
    if (v.exp == `FCX_EXP_MAX)
    begin
      if (!v.sig[`FCX_JBIT])
        k.uns = 1'b1;
      else if (v.sig[`FCX_JBIT-1:0] == '0)
        k.inf = 1'b1;
      else
      begin
        k.nan  = 1'b1;
        k.snan = !v.sig[`FCX_QBIT];
      end
    end
    else if (v.exp == '0)
    begin
      if (v.sig == '0)
        k.zero = 1'b1;
      else
        k.den = 1'b1;
    end
    else if (!v.sig[`FCX_JBIT])
      k.uns = 1'b1;
    return k;
  endfunction

  // signed integer magnitude to extended real
  function automatic fcx_ext_t int2ext(input logic s, input logic [15:0] m);
    fcx_ext_t r;
    int       p;
    r = '0;
    p = 0;
    for (int k = 0; k < 16; k++)
      if (m[k])
        p = k;
    r.sign = s;
    if (m != '0)
    begin
      r.exp = `FCX_BIAS + 15'(p);
      r.sig = 64'(m) << (63 - p);
    end
    return r;
  endfunction

  fcx_ext_t       stk [STK_DEPTH];     // physical stack registers
  logic [STK_DEPTH-1:0] tag_empty_reg; // one per register, 1 = empty
  logic [PW-1:0]  top_reg;             // stack pointer field
  fcx_stat_t      stat_reg;            // condition bits and flags
  fcx_stat_t      stat_next;
  fcx_ctl_t       ctl_reg;             // exception masks
  logic [PW-1:0]  sel_reg;             // register picked for port access
  logic [3*`FCX_WORD-1:0] stage_reg;   // staging of a value to load
  fcx_evt_t       istat_reg;           // sticky interrupt status
  fcx_evt_t       istat_next;
  fcx_evt_t       imask_reg;           // interrupt mask
  fcx_evt_t       evt;                 // events of this cycle
  logic [31:0]    rdata_reg;
  logic           done_reg;
  logic           nm_reg;
  logic           irq_reg;

  // issue and decode
  logic           nm;        // blocked by control register zero
  logic           go;        // instruction executes this cycle
  fcx_op_t        op;
  logic [PW-1:0]  p0, pi, pm;
  fcx_ext_t       a, b;
  fcx_kind_t      ka, kb;
  logic           ea, eb, is_cmp, uf, of;
  logic           cmp_inv, cmp_nan;
  logic [2:0]     rel, xam_code, cc3;
  fcx_ext_t       exp_val, sig_val;
  logic           xt_inv, xt_ok, wr_stat;

  assign nm      = instr_in.valid && (emulate_bit || task_switched_bit);
  assign go      = instr_in.valid && !(emulate_bit || task_switched_bit);
  assign wr_stat = reg_wr && reg_addr == `FCX_A_STAT;

  // opcode decode; the low three bits of the second byte give the index
  always_comb
  begin
    op = OP_NONE;
    if (instr_in.esc == `FCX_ESC_DD && instr_in.mrm[7:3] == `FCX_MRM_UCOM)
      op = OP_UCOM;
    else if (instr_in.esc == `FCX_ESC_DD && instr_in.mrm[7:3] == `FCX_MRM_UCOMP)
      op = OP_UCOMP;
    else if (instr_in.esc == `FCX_ESC_DA && instr_in.mrm == `FCX_MRM_UCOMPP)
      op = OP_UCOMPP;
    else if (instr_in.esc == `FCX_ESC_D9 && instr_in.mrm == `FCX_MRM_XAM)
      op = OP_XAM;
    else if (instr_in.esc == `FCX_ESC_D9 && instr_in.mrm[7:3] == `FCX_MRM_XCH)
      op = OP_XCH;
    else if (instr_in.esc == `FCX_ESC_D9 && instr_in.mrm == `FCX_MRM_XTRACT)
      op = OP_XTRACT;
  end

  // operands: top, indexed register (index 1 in the double-pop form, from its second byte)
  assign p0 = top_reg;
  assign pi = top_reg + PW'(instr_in.mrm[2:0]);
  assign pm = top_reg - PW'(1);
  assign a  = stk[p0];
  assign b  = stk[pi];
  assign ka = classify(a);
  assign kb = classify(b);
  assign ea = tag_empty_reg[p0];
  assign eb = tag_empty_reg[pi];
  assign is_cmp  = op == OP_UCOM || op == OP_UCOMP || op == OP_UCOMPP;
  assign uf = ea || ((is_cmp || op == OP_XCH) && eb);
  assign of = !tag_empty_reg[pm];
  assign cmp_inv = ka.snan || ka.uns || kb.snan || kb.uns;
  assign cmp_nan = ka.nan || kb.nan;
  assign cc3 = {stat_reg.c3, stat_reg.c2, stat_reg.c0};

  // relation of ordered operands, zero sign ignored
  always_comb
  begin
    if (ka.zero && kb.zero)
      rel = `FCX_CC_EQ;
    else if (a.sign != b.sign)
      rel = a.sign ? `FCX_CC_LT : `FCX_CC_GT;
    else if ({a.exp, a.sig} == {b.exp, b.sig})
      rel = `FCX_CC_EQ;
    else
      rel = (({a.exp, a.sig} > {b.exp, b.sig}) ^ a.sign) ? `FCX_CC_GT : `FCX_CC_LT;
  end

  // class code of the top register
  always_comb
  begin
    if (ea)
      xam_code = `FCX_CL_EMP;
    else if (ka.uns)
      xam_code = `FCX_CL_UNS;
    else if (ka.nan)
      xam_code = `FCX_CL_NAN;
    else if (ka.inf)
      xam_code = `FCX_CL_INF;
    else if (ka.zero)
      xam_code = `FCX_CL_ZER;
    else if (ka.den)
      xam_code = `FCX_CL_DEN;
    else
      xam_code = `FCX_CL_NRM;
  end

  // split results: exponent for the old top, significand for the push
  always_comb
  begin
    logic [15:0] e;
    e = '0;
    exp_val = a;
    sig_val = a;
    sig_val.exp = `FCX_BIAS;
    if (ka.zero)
    begin
      exp_val = {1'b1, `FCX_EXP_MAX, `FCX_INF_SIG};
      sig_val = '0;
      sig_val.sign = a.sign;
    end
    else if (ka.inf)
    begin
      exp_val = {1'b0, `FCX_EXP_MAX, `FCX_INF_SIG};
      sig_val = a;
    end
    else if (ka.nan || ka.uns)
    begin
      exp_val.sig[`FCX_QBIT] = 1'b1;
      sig_val = exp_val;
    end
    else
    begin
      // denormals carry the minimum true exponent
      e = {1'b0, (ka.den ? 15'h1 : a.exp)} - {1'b0, `FCX_BIAS};
      exp_val = int2ext(e[15], e[15] ? 16'(-e) : e);
    end
  end
  assign xt_inv = ka.snan || ka.uns;
  assign xt_ok  = !ea && !of && !(xt_inv && !ctl_reg.im) && !(ka.zero && !ctl_reg.zm);

  // events of the cycle
  always_comb
  begin
    evt      = '0;
    evt.nm   = nm;
    evt.done = go && op != OP_NONE;
    if (go && is_cmp)
    begin
      evt.sf = uf;
      evt.ie = !uf && cmp_inv;
      evt.de = !uf && (ka.den || kb.den);
    end
    if (go && op == OP_XCH)
      evt.sf = uf;
    if (go && op == OP_XTRACT)
    begin
      evt.sf = ea || of;
      evt.ie = !ea && !of && xt_inv;
      evt.de = !ea && !of && ka.den;
      evt.ze = !ea && !of && ka.zero;
    end
  end

  // status word next value; hardware events win over a software write
  always_comb
  begin
    stat_next = stat_reg;
    if (wr_stat)
      stat_next = fcx_stat_t'(reg_wdata[$bits(fcx_stat_t)-1:0]);
    stat_next.sf = stat_next.sf | evt.sf;
    stat_next.ie = stat_next.ie | evt.ie;
    stat_next.de = stat_next.de | evt.de;
    stat_next.ze = stat_next.ze | evt.ze;
    if (go)
    begin
      case (op)
        OP_UCOM, OP_UCOMP, OP_UCOMPP:
        begin
          if (uf)
            stat_next.c1 = 1'b0;
          if (uf || cmp_inv)
          begin
            if (ctl_reg.im)
              {stat_next.c3, stat_next.c2, stat_next.c0} = `FCX_CC_UN;
          end
          else if (cmp_nan)
            {stat_next.c3, stat_next.c2, stat_next.c0} = `FCX_CC_UN;
          else
            {stat_next.c3, stat_next.c2, stat_next.c0} = rel;
        end
        OP_XAM:
        begin
          stat_next.c1 = a.sign;
          {stat_next.c3, stat_next.c2, stat_next.c0} = xam_code;
        end
        OP_XCH:
          stat_next.c1 = 1'b0;
        OP_XTRACT:
          stat_next.c1 = !ea && of;
        default:
          stat_next = stat_next;
      endcase
    end
  end

  // status word register
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      stat_reg <= '0;
    else
      stat_reg <= stat_next;
  end

  // stack pointer; a pop or a push overrides a port write of the same cycle
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      top_reg <= '0;
    else if (go && op == OP_UCOMP)
      top_reg <= top_reg + PW'(1);
    else if (go && op == OP_UCOMPP)
      top_reg <= top_reg + PW'(2);
    else if (go && op == OP_XTRACT && xt_ok)
      top_reg <= pm;
    else if (wr_stat)
      top_reg <= reg_wdata[$bits(fcx_stat_t) +: PW];
  end

  // tags: pops mark empty, the push marks full
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      tag_empty_reg <= '1;
    else
    begin
      if (reg_wr && reg_addr == `FCX_A_TAG)
        tag_empty_reg <= reg_wdata[STK_DEPTH-1:0];
      if (go && (op == OP_UCOMP || op == OP_UCOMPP))
        tag_empty_reg[p0] <= 1'b1;
      if (go && op == OP_UCOMPP)
        tag_empty_reg[p0 + PW'(1)] <= 1'b1;
      if (go && op == OP_XTRACT && xt_ok)
        tag_empty_reg[pm] <= 1'b0;
    end
  end

  // stack contents: port load, exchange, split
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int k = 0; k < STK_DEPTH; k++)
        stk[k] <= '0;
    end
    else if (go && op == OP_XCH && !uf)
    begin
      stk[p0] <= b;
      stk[pi] <= a;
    end
    else if (go && op == OP_XTRACT && xt_ok)
    begin
      stk[p0] <= exp_val;
      stk[pm] <= sig_val;
    end
    else if (reg_wr && reg_addr == `FCX_A_COMMIT)
      stk[sel_reg] <= stage_reg[$bits(fcx_ext_t)-1:0];
  end

  // control, select and staging registers
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctl_reg   <= `FCX_CTL_RST;
      sel_reg   <= '0;
      stage_reg <= '0;
      imask_reg <= '0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `FCX_A_CTRL:  ctl_reg <= fcx_ctl_t'(reg_wdata[$bits(fcx_ctl_t)-1:0]);
        `FCX_A_SEL:   sel_reg <= reg_wdata[PW-1:0];
        `FCX_A_D0:    stage_reg[0 +: `FCX_WORD] <= reg_wdata;
        `FCX_A_D1:    stage_reg[`FCX_D1_SH +: `FCX_WORD] <= reg_wdata;
        `FCX_A_D2:    stage_reg[`FCX_D2_SH +: `FCX_WORD] <= reg_wdata;
        `FCX_A_IMASK: imask_reg <= fcx_evt_t'(reg_wdata[$bits(fcx_evt_t)-1:0]);
        default:      sel_reg <= sel_reg;
      endcase
    end
  end

  // interrupt status: read clears, a new event in that cycle survives
  always_comb
  begin
    istat_next = istat_reg;
    if (reg_rd && reg_addr == `FCX_A_ISTAT)
      istat_next = '0;
    istat_next = istat_next | evt;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      istat_reg <= '0;
      irq_reg   <= 1'b0;
    end
    else
    begin
      istat_reg <= istat_next;
      irq_reg   <= |(istat_next & imask_reg);
    end
  end

  // read data, valid in the cycle after the strobe only
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      rdata_reg <= '0;
    else if (!reg_rd)
      rdata_reg <= '0;
    else
    begin
      case (reg_addr)
        `FCX_A_CTRL:  rdata_reg <= 32'(ctl_reg);
        `FCX_A_STAT:  rdata_reg <= 32'({top_reg, stat_reg});
        `FCX_A_TAG:   rdata_reg <= 32'(tag_empty_reg);
        `FCX_A_SEL:   rdata_reg <= 32'(sel_reg);
        `FCX_A_D0:    rdata_reg <= 32'(stk[sel_reg]);
        `FCX_A_D1:    rdata_reg <= 32'(stk[sel_reg] >> `FCX_D1_SH);
        `FCX_A_D2:    rdata_reg <= 32'(stk[sel_reg] >> `FCX_D2_SH);
        `FCX_A_ISTAT: rdata_reg <= 32'(istat_reg);
        `FCX_A_IMASK: rdata_reg <= 32'(imask_reg);
        default:      rdata_reg <= '0;
      endcase
    end
  end

  // completion and fault pulses
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      done_reg <= 1'b0;
      nm_reg   <= 1'b0;
    end
    else
    begin
      done_reg <= evt.done;
      nm_reg   <= nm;
    end
  end

  assign reg_rdata  = rdata_reg;
  assign instr_done = done_reg;
  assign device_unavailable_fault = nm_reg;
  assign status_word = stat_reg;
  assign irq         = irq_reg;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_pop_once;
    go && op == OP_UCOMP;
  endsequence
  sequence s_popped(logic [PW-1:0] t);
    top_reg == t + PW'(1) && tag_empty_reg[t];
  endsequence

  chk_pop_once: assert property (
    s_pop_once |=> s_popped($past(top_reg)))
    else $error("single pop did not empty top and advance pointer");
  chk_pop_twice: assert property (
    go && op == OP_UCOMPP |=> top_reg == $past(top_reg) + PW'(2))
    else $error("double pop did not advance pointer by two");
  chk_zero_equal: assert property (
    go && is_cmp && !uf && ka.zero && kb.zero |=> cc3 == `FCX_CC_EQ)
    else $error("zeros did not compare equal");
  chk_qnan_quiet: assert property (
    go && is_cmp && !uf && cmp_nan && !cmp_inv |-> !evt.ie ##1 cc3 == `FCX_CC_UN)
    else $error("quiet NaN mishandled");
  chk_unmasked_cc: assert property (
    go && is_cmp && (uf || cmp_inv) && !ctl_reg.im |=> $stable(cc3))
    else $error("unmasked invalid compare changed condition bits");
  chk_xam_sign: assert property (
    go && op == OP_XAM |=> stat_reg.c1 == $past(a.sign) && cc3 == $past(xam_code))
    else $error("examine sign or class wrong");
  chk_xch_swap: assert property (
    go && op == OP_XCH && !uf |=> !stat_reg.c1 && stk[$past(p0)] == $past(b))
    else $error("exchange result wrong");
  chk_xtract_push: assert property (
    go && op == OP_XTRACT && xt_ok |=> top_reg == $past(pm) && !tag_empty_reg[top_reg])
    else $error("split did not push");
  chk_overflow_c1: assert property (
    go && op == OP_XTRACT && !ea && of |=> stat_reg.c1 && stat_reg.sf)
    else $error("overflow not reported");
  chk_nm_block: assert property (
    nm |=> device_unavailable_fault && !instr_done && $stable(top_reg))
    else $error("blocked instruction executed");
endmodule

// >>> verification/fcx_issue_model.sv
// fcx_issue_model.sv: core-side instruction issue for the fcx unit
// assumes: the bench calls send from one process, between clock edges
`timescale 1ns/1ns
module fcx_issue_model
(
  input  wire logic          ref_clk,
  output fcx_pkg::fcx_instr_t instr_in
);
  import fcx_pkg::*;
  // idle at time zero: no strobe
  initial instr_in = '0;
  // one-cycle strobe; afterwards the bytes turn over so stale opcodes never linger
  task automatic send(input logic [7:0] esc, input logic [7:0] mrm);
    @(posedge ref_clk);
    instr_in <= {1'b1, esc, mrm};
    @(posedge ref_clk);
    instr_in <= {1'b0, ~esc, ~mrm};
  endtask
endmodule

// >>> verification/fcx_unit_bench.sv
// fcx_unit_bench.sv: self-checking bench of the compare, examine, exchange and split unit
// assumes: the unit answers one cycle after each register read or instruction strobe
`timescale 1ns/1ns
module fcx_unit_bench;
  import fcx_pkg::*;
  // extended-real operands {sign, exponent, significand}
  localparam fcx_ext_t P1 = {1'b0, 15'h3FFF, 64'h8000000000000000};
  localparam fcx_ext_t P2 = {1'b0, 15'h4000, 64'h8000000000000000};
  localparam fcx_ext_t P3 = {1'b0, 15'h4000, 64'hC000000000000000};
  localparam fcx_ext_t P8 = {1'b0, 15'h4002, 64'h8000000000000000};
  localparam fcx_ext_t NZ = {1'b1, 15'h0000, 64'h0000000000000000};
  localparam fcx_ext_t PZ = {1'b0, 15'h0000, 64'h0000000000000000};
  localparam fcx_ext_t QN = {1'b0, 15'h7FFF, 64'hC000000000000000};
  localparam fcx_ext_t SN = {1'b0, 15'h7FFF, 64'hA000000000000000};
  localparam fcx_ext_t DN = {1'b0, 15'h0000, 64'h0000000000000001};
  localparam fcx_ext_t NI = {1'b1, 15'h7FFF, 64'h8000000000000000};
  // examine table: unsupported, nan, -normal, -inf, zero, empty, denormal
  localparam fcx_ext_t XV [7] = '{{1'b0, 15'h4000, 64'h0}, QN,
                                  {1'b1, 15'h3FFF, 64'h8000000000000000}, NI, PZ, NZ, DN};
  localparam logic [3:0] XC [7] = '{4'h0, 4'h1, 4'h6, 4'h7, 4'h8, 4'hB, 4'hC};
  logic        ref_clk;
  logic        nrst;
  logic        emulate_bit;
  logic        task_switched_bit;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        instr_done;
  logic        device_unavailable_fault;
  logic        irq;
  fcx_stat_t   status_word;
  fcx_instr_t  instr_in;
  int          n_fail;
  int          tests_run;
  fcx_unit u_fcx_unit (.instr_in, .emulate_bit, .task_switched_bit, .reg_addr, .reg_wdata,
                       .reg_wr, .reg_rd, .reg_rdata, .instr_done, .device_unavailable_fault,
                       .status_word, .irq, .ref_clk, .nrst);
  fcx_issue_model u_fcx_issue_model (.ref_clk, .instr_in);
  // free-running 100 MHz clock
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;
  // verdict and end of run
  task automatic report_and_stop;
    if (n_fail == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // compare one value, count it, report a mismatch
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // one-cycle read; data is taken in the following cycle only
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  // load a stack register through the staging words and commit
  task automatic ldv(input logic [2:0] i, input fcx_ext_t v);
    wr(4'h3, {29'h0, i});
    wr(4'h4, v[31:0]);
    wr(4'h5, v[63:32]);
    wr(4'h6, {16'h0, v[79:64]});
    wr(4'h7, 32'h0);
  endtask
  // read back a stack register as three words
  task automatic cv(input logic [2:0] i, input fcx_ext_t v);
    wr(4'h3, {29'h0, i});
    rc(4'h4, v[31:0]);
    rc(4'h5, v[63:32]);
    rc(4'h6, {16'h0, v[79:64]});
  endtask
  // issue an opcode; it must complete in the next cycle without a fault
  task automatic op(input logic [7:0] e, input logic [7:0] m);
    u_fcx_issue_model.send(e, m);
    #1;
    chk({30'h0, instr_done, device_unavailable_fault}, 32'h2);
  endtask
  // issue and check {c3, c2, c1, c0}
  task automatic ex(input logic [7:0] e, input logic [7:0] m, input logic [3:0] c);
    op(e, m);
    chk({28'h0, status_word[7:4]}, {28'h0, c});
  endtask
  // sticky flags {sf, ze, de, ie}
  task automatic fl(input logic [3:0] f);
    chk({28'h0, status_word[3:0]}, {28'h0, f});
  endtask
  // issue while a blocking control bit is set: fault pulse instead of completion
  task automatic blk(input logic em, input logic ts);
    @(posedge ref_clk);
    emulate_bit       <= em;
    task_switched_bit <= ts;
    u_fcx_issue_model.send(8'hDD, 8'hE1);
    #1;
    chk({30'h0, instr_done, device_unavailable_fault}, 32'h1);
  endtask
  // reset values and an unmapped read
  task automatic t_reset;
    rc(4'h0, 32'h3);
    rc(4'h2, 32'hFF);
    rc(4'h1, 32'h0);
    rc(4'h9, 32'h0);
    rc(4'hF, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask
  // compares over seven loaded registers and one empty, exchanges, then single and double pop
  task automatic t_compare;
    ldv(3'h0, P1);
    ldv(3'h1, P2);
    ldv(3'h2, NZ);
    ldv(3'h3, PZ);
    ldv(3'h4, QN);
    ldv(3'h5, SN);
    ldv(3'h6, DN);
    wr(4'h2, 32'h80);
    ex(8'hDD, 8'hE1, 4'h1);
    ex(8'hDD, 8'hE4, 4'hD);
    fl(4'h0);
    ex(8'hDD, 8'hE2, 4'h0);
    op(8'hD9, 8'hCA);
    chk({31'h0, status_word.c1}, 32'h0);
    cv(3'h0, NZ);
    cv(3'h2, P1);
    ex(8'hDD, 8'hE3, 4'h8);
    ex(8'hDD, 8'hE5, 4'hD);
    fl(4'h1);
    wr(4'h0, 32'h2);
    ex(8'hDD, 8'hE3, 4'h8);
    ex(8'hDD, 8'hE5, 4'h8);
    wr(4'h0, 32'h3);
    ex(8'hDD, 8'hE6, 4'h1);
    fl(4'h3);
    ex(8'hDD, 8'hE7, 4'hD);
    fl(4'hB);
    op(8'hD9, 8'hC9);
    cv(3'h0, P2);
    ex(8'hDD, 8'hE9, 4'h0);
    rc(4'h1, 32'h10B);
    rc(4'h2, 32'h81);
    ex(8'hDA, 8'hE9, 4'h1);
    rc(4'h1, 32'h31B);
    rc(4'h2, 32'h87);
  endtask
  // every class code, with the sign copied even from an empty register
  task automatic t_examine;
    for (int k = 0; k < 7; k++)
    begin
      wr(4'h1, 32'h0);
      ldv(3'h0, XV[k]);
      wr(4'h2, (k == 5) ? 32'hFF : 32'hFE);
      ex(8'hD9, 8'hE5, XC[k]);
    end
  endtask
  // split of 8.0, then a push onto a full register, then a masked zero
  task automatic t_split;
    wr(4'h1, 32'h0);
    wr(4'h2, 32'hFE);
    ldv(3'h0, P8);
    op(8'hD9, 8'hF4);
    rc(4'h1, 32'h700);
    rc(4'h2, 32'h7E);
    cv(3'h7, P1);
    cv(3'h0, P3);
    wr(4'h1, 32'h0);
    op(8'hD9, 8'hF4);
    rc(4'h1, 32'h28);
    cv(3'h0, P3);
    wr(4'h1, 32'h0);
    wr(4'h2, 32'hFE);
    ldv(3'h0, NZ);
    op(8'hD9, 8'hF4);
    cv(3'h7, NZ);
    cv(3'h0, NI);
  endtask
  // completion interrupt: raised, cleared by reading, then masked
  task automatic t_irq;
    logic [31:0] d;
    rd(4'h8, d);
    wr(4'h9, 32'h1);
    op(8'hDD, 8'hE1);
    @(posedge ref_clk);
    #1 chk({31'h0, irq}, 32'h1);
    rc(4'h8, 32'h1);
    @(posedge ref_clk);
    #1 chk({31'h0, irq}, 32'h0);
    wr(4'h9, 32'h0);
    op(8'hDD, 8'hE1);
    repeat (2) @(posedge ref_clk);
    #1 chk({31'h0, irq}, 32'h0);
  endtask
  // main sequence
  initial
  begin
    nrst              = 1'b0;
    emulate_bit       = 1'b0;
    task_switched_bit = 1'b0;
    reg_addr          = 4'h0;
    reg_wdata         = 32'h0;
    reg_wr            = 1'b0;
    reg_rd            = 1'b0;
    n_fail            = 0;
    tests_run         = 0;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset;
    t_compare;
    t_examine;
    t_split;
    blk(1'b1, 1'b0);
    blk(1'b0, 1'b1);
    @(posedge ref_clk);
    task_switched_bit <= 1'b0;
    t_irq;
    report_and_stop;
  end
  // hang guard
  initial
  begin
    #900000;
    n_fail++;
    report_and_stop;
  end
endmodule
